/* File: rtl/fts_pkg.sv */
// Shared constants, types and register map of the flow-through SRAM data path.
package fts_pkg;

  // ----------------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------------
  localparam int ADDR_W  = 19;
  localparam int DEPTH   = 524288;
  localparam int LANES   = 2;
  localparam int BYTE_W  = 8;
  localparam int DQ_W    = LANES * BYTE_W;
  localparam int BURST_W = 2;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_STATUS    = 8'h04;
  localparam logic [7:0]  OFS_CAPTURE   = 8'h08;
  localparam int          CTRL_FLOAT_B  = 0;
  localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
  localparam int          ST_STATE_LSB  = 0;
  localparam int          ST_WAKE_B     = 3;
  localparam int          ST_MODE_B     = 4;
  localparam int          ST_DRIVE_B    = 5;
  localparam int          ST_BURST_LSB  = 8;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_DESEL = 3'b001,
    ST_READ  = 3'b010,
    ST_WRITE = 3'b100
  } fts_state_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              adv_ld;
    logic              we_n;
    logic [LANES-1:0]  byte_write_select_n;
    logic              chip_select_one_n;
    logic              chip_select_two;
    logic              chip_select_three_n;
    logic              clock_qualifier_n;
  } fts_ctl_s;

  typedef struct packed {
    logic [LANES-1:0] parity_lines;
    logic [DQ_W-1:0]  dq;
  } fts_data_s;

endpackage

/* File: rtl/fts_burst_order.sv */
// Burst offset generator: linear or interleaved order of the low address bits.
`timescale 1ns/10ps
module fts_burst_order (
  input  wire logic [fts_pkg::BURST_W-1:0] base,
  input  wire logic [fts_pkg::BURST_W-1:0] count,
  input  wire logic                        interleave,
  output logic      [fts_pkg::BURST_W-1:0] offset
);
  import fts_pkg::*;

  wire [BURST_W-1:0] linear_off = base + count;
  wire [BURST_W-1:0] inter_off  = base ^ count;

  assign offset = interleave ? inter_off : linear_off;

endmodule

/* File: rtl/fts_data_io.sv */
// Flow-through SRAM data and parity lanes with APB status and control.
`timescale 1ns/10ps
module fts_data_io (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire fts_pkg::fts_ctl_s         ctl,
  input  wire logic                      output_enable_n,
  input  wire fts_pkg::fts_data_s        lines_in,
  output fts_pkg::fts_data_s             lines_out,
  output logic      [fts_pkg::DQ_W-1:0]  dq_oe,
  output logic      [fts_pkg::LANES-1:0] parity_oe,
  input  wire logic                      burst_mode_strap,
  input  wire logic                      test_clock,
  input  wire logic                      scan_in,
  output logic                           scan_out
);
  import fts_pkg::*;

  // ----------------------------------------------------------------------
  // Pin synchronisers for the asynchronous inputs
  // ----------------------------------------------------------------------
  logic [1:0] oe_sync_reg;
  logic [1:0] mode_sync_reg;
  logic [1:0] tck_sync_reg;
  logic [1:0] tdi_sync_reg;
  logic       tck_last_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_sync_reg   <= 2'h3;
      mode_sync_reg <= 2'h3;
      tck_sync_reg  <= 2'h0;
      tdi_sync_reg  <= 2'h0;
      tck_last_reg  <= 1'b0;
    end else begin
      oe_sync_reg   <= {oe_sync_reg[0], output_enable_n};
      mode_sync_reg <= {mode_sync_reg[0], burst_mode_strap};
      tck_sync_reg  <= {tck_sync_reg[0], test_clock};
      tdi_sync_reg  <= {tdi_sync_reg[0], scan_in};
      tck_last_reg  <= tck_sync_reg[1];
    end
  end

  // ----------------------------------------------------------------------
  // Strap capture after reset release
  // ----------------------------------------------------------------------
  // The strap is meant to be static, so it is caught once and then held;
  // a later change at the pin cannot reorder a burst in flight.
  // The synchroniser still shows its reset value for two edges after
  // release, so the strap is taken at the third edge.
  logic [1:0] strap_cnt_reg;
  logic       interleave_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_cnt_reg  <= 2'h0;
      interleave_reg <= 1'b1;
    end else if (strap_cnt_reg != 2'h3) begin
      strap_cnt_reg <= strap_cnt_reg + 2'h1;
      if (strap_cnt_reg == 2'h2)
        interleave_reg <= mode_sync_reg[1];
    end
  end

  // ----------------------------------------------------------------------
  // Access sequencer
  // ----------------------------------------------------------------------
  fts_state_e         state_reg;
  fts_state_e         state_next;
  logic [ADDR_W-1:0]  addr_reg;
  logic [BURST_W-1:0] burst_cnt_reg;
  logic [LANES-1:0]   bw_n_reg;
  logic               wake_reg;
  fts_data_s          capture_reg;
  logic [31:0]        ctrl_reg;

  wire clk_en   = !ctl.clock_qualifier_n;
  wire selected = !ctl.chip_select_one_n && ctl.chip_select_two &&
                  !ctl.chip_select_three_n;
  wire load     = !ctl.adv_ld;

  always_comb begin
    state_next = state_reg;
    if (load) begin
      if (!selected)
        state_next = ST_DESEL;
      else if (ctl.we_n)
        state_next = ST_READ;
      else
        state_next = ST_WRITE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg     <= ST_DESEL;
      addr_reg      <= '0;
      burst_cnt_reg <= '0;
      bw_n_reg      <= '1;
      wake_reg      <= 1'b0;
      capture_reg   <= '0;
    end else if (clk_en) begin
      state_reg   <= state_next;
      wake_reg    <= (state_reg == ST_DESEL) && (state_next != ST_DESEL);
      capture_reg <= lines_in;
      if (load) begin
        addr_reg      <= ctl.addr;
        burst_cnt_reg <= '0;
        bw_n_reg      <= ctl.byte_write_select_n;
      end else begin
        burst_cnt_reg <= burst_cnt_reg + 2'h1;
      end
    end
  end

  logic [BURST_W-1:0] burst_off;

  fts_burst_order u_burst (
    .base       (addr_reg[BURST_W-1:0]),
    .count      (burst_cnt_reg),
    .interleave (interleave_reg),
    .offset     (burst_off)
  );

  wire [ADDR_W-1:0] cur_addr = {addr_reg[ADDR_W-1:BURST_W], burst_off};

  // ----------------------------------------------------------------------
  // Byte lanes: one array per lane, each byte with its parity bit
  // ----------------------------------------------------------------------
  wire do_write = clk_en && (state_reg == ST_WRITE);
  wire [DQ_W-1:0]  rd_dq;
  wire [LANES-1:0] rd_par;

  for (genvar g = 0; g < LANES; g++) begin : g_lane
    logic [BYTE_W:0] lane_mem [DEPTH];
    logic [BYTE_W:0] rd_word;

    always_ff @(posedge pclk) begin
      if (do_write && !bw_n_reg[g])
        lane_mem[cur_addr] <= {lines_in.parity_lines[g],
                               lines_in.dq[g*BYTE_W +: BYTE_W]};
    end

    assign rd_word = lane_mem[cur_addr];
    assign rd_dq[g*BYTE_W +: BYTE_W] = rd_word[BYTE_W-1:0];
    assign rd_par[g]                 = rd_word[BYTE_W];
  end

  assign lines_out = {rd_par, rd_dq};

  // ----------------------------------------------------------------------
  // Drive direction
  // ----------------------------------------------------------------------
  // The enable path adds two pclk cycles of latency to the pin because the
  // enable is asynchronous; the controller must allow for it.
  wire is_read  = (state_reg == ST_READ);
  wire drive_en = is_read && !oe_sync_reg[1] && !wake_reg &&
                  !ctrl_reg[CTRL_FLOAT_B];

  assign dq_oe     = {DQ_W{drive_en}};
  assign parity_oe = {LANES{drive_en}};

  // ----------------------------------------------------------------------
  // Scan output stage
  // ----------------------------------------------------------------------
  logic scan_hold_reg;
  logic scan_out_reg;

  wire tck_rise = tck_sync_reg[1] && !tck_last_reg;
  wire tck_fall = !tck_sync_reg[1] && tck_last_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_hold_reg <= 1'b0;
      scan_out_reg  <= 1'b0;
    end else begin
      if (tck_rise)
        scan_hold_reg <= tdi_sync_reg[1];
      if (tck_fall)
        scan_out_reg <= scan_hold_reg;
    end
  end

  assign scan_out = scan_out_reg;

  // ----------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------
  wire hit_ctrl    = (paddr == OFS_CTRL);
  wire hit_status  = (paddr == OFS_STATUS);
  wire hit_capture = (paddr == OFS_CAPTURE);
  wire mapped      = hit_ctrl || hit_status || hit_capture;
  wire access      = psel && penable;
  wire wr_ctrl     = access && pwrite && hit_ctrl;

  wire [31:0] status_word =
    (32'(state_reg) << ST_STATE_LSB) |
    (32'(wake_reg) << ST_WAKE_B) |
    (32'(interleave_reg) << ST_MODE_B) |
    (32'(drive_en) << ST_DRIVE_B) |
    (32'(burst_off) << ST_BURST_LSB);

  wire [31:0] rd_mux = hit_ctrl    ? ctrl_reg :
                       hit_status  ? status_word :
                       hit_capture ? 32'(capture_reg) : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RST;
      prdata   <= 32'h0000_0000;
    end else begin
      if (wr_ctrl)
        ctrl_reg <= {31'h0000_0000, pwdata[CTRL_FLOAT_B]};
      if (psel && !penable && !pwrite)
        prdata <= rd_mux;
    end
  end

  assign pready  = 1'b1;
  assign pslverr = access && !mapped;

endmodule

/* File: verif/fts_data_io_asserts.sv */
// Concurrent checks on the SRAM data lanes and the APB port.
`timescale 1ns/10ps
module fts_data_io_asserts (
  input wire logic                      pclk,
  input wire logic                      presetn,
  input wire logic                      psel,
  input wire logic                      penable,
  input wire logic [7:0]                paddr,
  input wire logic                      pready,
  input wire logic                      pslverr,
  input wire fts_pkg::fts_ctl_s         ctl,
  input wire logic                      output_enable_n,
  input wire logic [fts_pkg::DQ_W-1:0]  dq_oe,
  input wire logic [fts_pkg::LANES-1:0] parity_oe,
  input wire logic                      test_clock,
  input wire logic                      scan_out
);
  import fts_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire  sel   = !ctl.chip_select_one_n && ctl.chip_select_two &&
                !ctl.chip_select_three_n;
  wire  ld    = !ctl.clock_qualifier_n && !ctl.adv_ld;
  wire  ld_rd = ld && sel && ctl.we_n;
  wire  ld_wr = ld && sel && !ctl.we_n;
  wire  ld_ds = ld && !sel;
  wire  off   = dq_oe == '0 && parity_oe == '0;
  wire  all_drv = &dq_oe && &parity_oe;
  logic prev_rd;
  // A read after a read is never a wake cycle, so it must drive.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_rd <= 1'b0;
    end else if (!ctl.clock_qualifier_n) begin
      prev_rd <= ld_rd;
    end
  end
  chk_read_drive: assert property (
    !output_enable_n [*3] ##0 (ld_rd && prev_rd) |=> all_drv)
    else $error("Read data not driven.");
  chk_oe_float: assert property (
    output_enable_n [*3] |-> off) else $error("Driving with oe high.");
  chk_write_float: assert property (
    ld_wr |=> off) else $error("Driving in write data phase.");
  chk_wake_float: assert property (
    ld_ds ##1 ld_rd |=> off) else $error("Driving in wake cycle.");
  chk_desel_float: assert property (
    ld_ds |=> off) else $error("Driving after deselect.");
  chk_freeze_hold: assert property (
    $stable(output_enable_n) [*3] ##0 ctl.clock_qualifier_n
    |=> $stable(dq_oe)) else $error("State moved while frozen.");
  chk_scan_edge: assert property (
    $changed(scan_out) |-> !$past(test_clock, 2))
    else $error("Scan output moved off test clock fall.");
  chk_apb_ready: assert property (
    psel && penable |-> pready) else $error("Access not ready.");
  chk_apb_err: assert property (
    psel && penable && paddr > 8'h08 |-> pslverr)
    else $error("Unmapped access without error.");
endmodule
bind fts_data_io fts_data_io_asserts u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .ctl(ctl),
  .output_enable_n(output_enable_n), .dq_oe(dq_oe),
  .parity_oe(parity_oe), .test_clock(test_clock), .scan_out(scan_out));

/* File: verif/fts_ctrl_model.sv */
// Controller side of the shared data and parity lanes.
`timescale 1ns/10ps
module fts_ctrl_model (
  input wire logic                      pclk,
  input wire fts_pkg::fts_ctl_s         ctl,
  input wire fts_pkg::fts_data_s        wdata,
  input wire fts_pkg::fts_data_s        lines_out,
  input wire logic [fts_pkg::DQ_W-1:0]  dq_oe,
  input wire logic [fts_pkg::LANES-1:0] parity_oe,
  output fts_pkg::fts_data_s            lines_in
);
  import fts_pkg::*;
  logic      drv  = 1'b0;
  fts_data_s last = '0;
  wire       wr   = !ctl.clock_qualifier_n && !ctl.adv_ld && !ctl.we_n &&
                    !ctl.chip_select_one_n && ctl.chip_select_two &&
                    !ctl.chip_select_three_n;
  wire [DQ_W+LANES-1:0] dev = {parity_oe, dq_oe};
  // Undriven lines flip each cycle so a stale level never reads as data.
  wire [DQ_W+LANES-1:0] own = drv ? wdata : ~last;
  assign lines_in = (dev & lines_out) | (~dev & own);
  always @(posedge pclk) begin
    if (!ctl.clock_qualifier_n) begin
      drv <= wr;
    end
    last <= lines_in;
  end
endmodule

/* File: verif/tb_fts_data_io.sv */
// Self-checking bench for the flow-through SRAM data lanes.
`timescale 1ns/10ps
module tb_fts_data_io;
  import fts_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic output_enable_n = 1, strap = 1, test_clock = 0, scan_in = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic pready, pslverr, scan_out, e;
  fts_ctl_s ctl = '1;
  fts_data_s wdata = '0, lines_in, lines_out, d1, d2, snap_d;
  logic [DQ_W-1:0] dq_oe;
  logic [LANES-1:0] parity_oe;
  logic [17:0] snap_oe, mrg;
  logic [ADDR_W-1:0] a;
  int errors = 0, checks = 0, tc = 0;
  integer seed = 32'h33965920;
  fts_data_io u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ctl(ctl),
    .output_enable_n(output_enable_n), .lines_in(lines_in),
    .lines_out(lines_out), .dq_oe(dq_oe), .parity_oe(parity_oe),
    .burst_mode_strap(strap), .test_clock(test_clock),
    .scan_in(scan_in), .scan_out(scan_out));
  fts_ctrl_model u_ctrl (.pclk(pclk), .ctl(ctl), .wdata(wdata),
    .lines_out(lines_out), .dq_oe(dq_oe), .parity_oe(parity_oe),
    .lines_in(lines_in));
  always #5 pclk = ~pclk;
  // Test clock is kept slow: five pclk cycles per phase.
  always @(posedge pclk) begin
    tc <= (tc == 4) ? 0 : tc + 1;
    if (tc == 4) begin
      test_clock <= ~test_clock;
      scan_in <= 1'($random(seed));
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    if (n >= 50) errors++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Snapshot shows the data cycle that follows the previous edge.
  task automatic op(input logic ld, wr, input logic [1:0] bw,
                    input logic sel, frz, input fts_data_s wd);
    ctl <= '{a, !ld, !wr, ~bw, !sel, sel, !sel, frz};
    wdata <= wd;
    @(negedge pclk);
    snap_d = lines_out;
    snap_oe = {parity_oe, dq_oe};
    @(posedge pclk);
  endtask
  function automatic logic [1:0] boff(logic [1:0] b, logic m);
    return m ? (b ^ 2'b01) : (b + 2'b01);
  endfunction
  task automatic test_done;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    for (int s = 0; s < 2; s++) begin
      presetn <= 1'b0;
      ctl <= '1;
      strap <= s[0];
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      a = ADDR_W'($random(seed));
      d1 = 18'($random(seed));
      d2 = 18'($random(seed));
      mrg = {d1[17], d2[16], d1[15:8], d2[7:0]};
      apb(1, OFS_CTRL, CTRL_RST);
      apb(1, OFS_STATUS, 32'hffffffff);
      apb(0, OFS_CTRL, 0);
      chk(r, CTRL_RST);
      output_enable_n <= 1'b0;
      op(1, 1, 2'b11, 1, 0, '0);
      op(1, 1, 2'b01, 1, 0, d1);
      op(1, 0, 2'b00, 1, 0, d2);
      op(0, 0, 2'b00, 1, 0, '0);
      chk(snap_d, mrg);
      chk(snap_oe, 18'h3ffff);
      repeat (2) op(0, 0, 2'b00, 1, 1, '0);
      apb(0, OFS_CAPTURE, 0);
      chk(r[17:0], mrg);
      apb(0, OFS_STATUS, 0);
      chk({r[9:8], r[4], r[2:0]},
          {boff(a[1:0], s[0]), s[0], 3'b010});
      apb(0, 8'h0c, 0);
      chk({e, r}, {1'b1, 32'h0});
      op(1, 0, 2'b00, 0, 0, '0);
      op(1, 0, 2'b00, 1, 0, '0);
      chk(snap_oe, 0);
      op(1, 0, 2'b00, 1, 0, '0);
      chk(snap_oe, 0);
      op(1, 0, 2'b00, 1, 0, '0);
      chk({snap_oe, snap_d}, {18'h3ffff, mrg});
      output_enable_n <= 1'b1;
      repeat (4) op(1, 0, 2'b00, 1, 0, '0);
      chk(snap_oe, 0);
      $display("strap %0d test done", s);
    end
    test_done;
  end
  // Both passes need well under 300 cycles; allow far more.
  initial begin
    #200000;
    errors++;
    test_done;
  end
endmodule
